/* seg_pm_pkg.sv */
`default_nettype none

package seg_pm_pkg;

  // Segment power states, two-bit encoded
  typedef enum logic [1:0] {
    BUS_B0 = 2'h0,
    BUS_B1 = 2'h1,
    BUS_B2 = 2'h2,
    BUS_B3 = 2'h3
  } bus_state_t;

  // Originating device power state as programmed by software
  typedef enum logic [2:0] {
    DEV_D0     = 3'h0,
    DEV_D1     = 3'h1,
    DEV_D2     = 3'h2,
    DEV_D3HOT  = 3'h3,
    DEV_D3COLD = 3'h4
  } dev_state_t;

  // Sequencer states, Gray along B0 -> drain -> B1 -> B2 -> B3 -> wake
  typedef enum logic [2:0] {
    ST_B0    = 3'h0,
    ST_DRAIN = 3'h1,
    ST_B1    = 3'h3,
    ST_B2    = 3'h2,
    ST_B3    = 3'h6,
    ST_WAKE  = 3'h7
  } seq_state_t;

  // Controls toward the segment's supply, clock source and reset
  typedef struct packed {
    logic pwr_en;
    logic clk_run;
    logic rst_n;
  } seg_ctrl_t;

  localparam seg_ctrl_t SEG_CTRL_RESET = '{pwr_en: 1'b1, clk_run: 1'b1, rst_n: 1'b1};

  // Timing
  localparam int SYS_CLK_PERIOD_NS = 25;
  localparam int SETTLE_TIME_MS    = 50;
  localparam int BUS_RST_TIME_US   = 1;
  localparam int SETTLE_CYCLES     = (SETTLE_TIME_MS * 1000000) / SYS_CLK_PERIOD_NS;
  localparam int BUS_RST_CYCLES    = (BUS_RST_TIME_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int IDLE_MIN_CYCLES   = 2;

endpackage

`default_nettype wire

/* level_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

`default_nettype wire

/* seg_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module seg_link_monitor #(
  parameter int IDLE_MIN = seg_pm_pkg::IDLE_MIN_CYCLES
) (
  // Segment clock and reset
  input  wire logic link_clk_in,
  input  wire logic reset_in,
  // Segment pins, synchronous to the segment clock
  input  wire logic frame_n_in,
  input  wire logic irdy_n_in,
  // From the system domain
  input  wire logic quiesce_in,
  // Link-domain results
  output logic      idle_out,
  output logic      gnt_block_out
);

  localparam int CW = $clog2(IDLE_MIN + 1);

  logic [CW-1:0] idle_cnt_r;
  logic [CW-1:0] idle_cnt_nxt;
  logic          idle_r;
  logic          idle_nxt;
  logic          block_r;
  logic          quiesce_sync;
  logic [1:0]    pin_sync;

  // Pins pass two flops; reset value reads as busy, so idle needs real high levels
  level_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk_in   (link_clk_in),
    .reset_in (reset_in),
    .async_in ({frame_n_in, irdy_n_in}),
    .sync_out (pin_sync)
  );

  level_sync #(
    .WIDTH (1)
  ) u_quiesce_sync (
    .clk_in   (link_clk_in),
    .reset_in (reset_in),
    .async_in (quiesce_in),
    .sync_out (quiesce_sync)
  );

  // Idle only after both FRAME# and IRDY# stayed high for a few clocks
  always_comb begin
    idle_cnt_nxt = idle_cnt_r;
    if (!pin_sync[1] || !pin_sync[0]) begin
      idle_cnt_nxt = '0;
    end else if (idle_cnt_r != CW'(IDLE_MIN)) begin
      idle_cnt_nxt = idle_cnt_r + CW'(1);
    end
    idle_nxt = (idle_cnt_nxt == CW'(IDLE_MIN));
  end

  always_ff @(posedge link_clk_in or posedge reset_in) begin
    if (reset_in) begin
      idle_cnt_r <= '0;
      idle_r     <= 1'b0;
      block_r    <= 1'b0;
    end else begin
      idle_cnt_r <= idle_cnt_nxt;
      idle_r     <= idle_nxt;
      block_r    <= quiesce_sync;
    end
  end

  assign idle_out      = idle_r;
  // Arbiter withholds grants, parking stays allowed
  assign gnt_block_out = block_r;

endmodule

`default_nettype wire

/* seg_power_seq.sv */
// Contract
// - Segment always in exactly one B-state
// - B0: full power, running clock, any transaction
// - Transactions only while segment is B0
// - Non-B0 downstream access ends as master abort
// - Leave B0 only after bus settles idle
// - B1: powered, permanently idle, no transactions
// - B1: clock keeps running freely
// - B1/B2: signals valid, parking allowed
// - B2: powered, clock stopped low
// - Low states: only PME, not forwarded
// - B3: segment supply removed, no clock
// - One power plane, one shared clock
// - Bus state follows device D-state
// - System reset returns segment to B0
// - B3 exit: assert bus reset, then idle
`timescale 1ns/1ps
`default_nettype none

module seg_power_seq #(
  parameter int SETTLE_CYCLES  = seg_pm_pkg::SETTLE_CYCLES,
  parameter int BUS_RST_CYCLES = seg_pm_pkg::BUS_RST_CYCLES
) (
  // System clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   reset_in,
  // Segment clock
  input  wire logic                   link_clk_in,
  // Power state control
  input  wire seg_pm_pkg::dev_state_t dev_state_in,
  input  wire logic                   d3hot_b2_in,
  // Upstream accesses toward the segment
  input  wire logic                   acc_req_in,
  output logic                        acc_ready_out,
  output logic                        acc_fwd_out,
  output logic                        master_abort_out,
  // Segment pins
  input  wire logic                   frame_n_in,
  input  wire logic                   irdy_n_in,
  output logic                        gnt_block_out,
  // Segment supply, clock and reset control
  output seg_pm_pkg::seg_ctrl_t       seg_ctrl_out,
  // Status
  output seg_pm_pkg::bus_state_t      bus_state_out,
  output logic                        settle_busy_out
);

  localparam int MAXC = (SETTLE_CYCLES > BUS_RST_CYCLES) ? SETTLE_CYCLES : BUS_RST_CYCLES;
  localparam int TW   = $clog2(MAXC + 1);

  seg_pm_pkg::seq_state_t state_r;
  seg_pm_pkg::seq_state_t state_nxt;
  seg_pm_pkg::bus_state_t bus_r;
  seg_pm_pkg::bus_state_t bus_nxt;
  seg_pm_pkg::bus_state_t tgt;
  seg_pm_pkg::seg_ctrl_t  ctrl_r;
  seg_pm_pkg::seg_ctrl_t  ctrl_nxt;
  logic [TW-1:0]          tmr_r;
  logic [TW-1:0]          tmr_nxt;
  logic                   abort_r;
  logic                   abort_nxt;
  logic                   quiesce_r;
  logic                   quiesce_nxt;
  logic                   idle_link;
  logic                   idle_sys;
  logic                   block_sys;
  logic                   acc_take;

  // Bus state that the device state calls for
  function automatic seg_pm_pkg::bus_state_t target_of(input seg_pm_pkg::dev_state_t d, input logic hot_b2);
    seg_pm_pkg::bus_state_t b;
    b = seg_pm_pkg::BUS_B0;
    unique case (d)
      seg_pm_pkg::DEV_D0:     b = seg_pm_pkg::BUS_B0;
      seg_pm_pkg::DEV_D1:     b = seg_pm_pkg::BUS_B1;
      seg_pm_pkg::DEV_D2:     b = seg_pm_pkg::BUS_B2;
      seg_pm_pkg::DEV_D3HOT:  b = hot_b2 ? seg_pm_pkg::BUS_B2 : seg_pm_pkg::BUS_B3;
      seg_pm_pkg::DEV_D3COLD: b = seg_pm_pkg::BUS_B3;
      default:                b = seg_pm_pkg::BUS_B0;
    endcase
    return b;
  endfunction

  // Sequencer state for a low bus state
  function automatic seg_pm_pkg::seq_state_t low_state_of(input seg_pm_pkg::bus_state_t b);
    seg_pm_pkg::seq_state_t s;
    s = seg_pm_pkg::ST_B1;
    unique case (b)
      seg_pm_pkg::BUS_B2: s = seg_pm_pkg::ST_B2;
      seg_pm_pkg::BUS_B3: s = seg_pm_pkg::ST_B3;
      default:            s = seg_pm_pkg::ST_B1;
    endcase
    return s;
  endfunction

  seg_link_monitor u_link (
    .link_clk_in   (link_clk_in),
    .reset_in      (reset_in),
    .frame_n_in    (frame_n_in),
    .irdy_n_in     (irdy_n_in),
    .quiesce_in    (quiesce_r),
    .idle_out      (idle_link),
    .gnt_block_out (gnt_block_out)
  );

  level_sync #(
    .WIDTH (1)
  ) u_idle_sync (
    .clk_in   (sys_clk_in),
    .reset_in (reset_in),
    .async_in (idle_link),
    .sync_out (idle_sys)
  );

  // Grant block echoed back so B0 is left only once arbitration is frozen
  level_sync #(
    .WIDTH (1)
  ) u_block_sync (
    .clk_in   (sys_clk_in),
    .reset_in (reset_in),
    .async_in (gnt_block_out),
    .sync_out (block_sys)
  );

  assign tgt = target_of(dev_state_in, d3hot_b2_in);

  // Stall while draining or waking so no access slips into a transition
  assign acc_ready_out = (state_r != seg_pm_pkg::ST_DRAIN) && (state_r != seg_pm_pkg::ST_WAKE);
  assign acc_take      = acc_req_in && acc_ready_out;
  assign acc_fwd_out   = acc_take && (bus_r == seg_pm_pkg::BUS_B0);

  always_comb begin
    state_nxt   = state_r;
    bus_nxt     = bus_r;
    tmr_nxt     = (tmr_r != '0) ? tmr_r - TW'(1) : tmr_r;
    abort_nxt   = acc_take && (bus_r != seg_pm_pkg::BUS_B0);
    unique case (state_r)
      seg_pm_pkg::ST_B0: begin
        if (tgt != seg_pm_pkg::BUS_B0) begin
          state_nxt = seg_pm_pkg::ST_DRAIN;
        end
      end
      seg_pm_pkg::ST_DRAIN: begin
        if (tgt == seg_pm_pkg::BUS_B0) begin
          state_nxt = seg_pm_pkg::ST_B0;
        end else if (idle_sys && block_sys && !acc_req_in) begin
          state_nxt = low_state_of(tgt);
          bus_nxt   = tgt;
          tmr_nxt   = '0;
        end
      end
      seg_pm_pkg::ST_B1,
      seg_pm_pkg::ST_B2: begin
        if (tgt == seg_pm_pkg::BUS_B0) begin
          state_nxt = seg_pm_pkg::ST_B0;
          bus_nxt   = seg_pm_pkg::BUS_B0;
          if (state_r == seg_pm_pkg::ST_B2) begin
            tmr_nxt = TW'(SETTLE_CYCLES);
          end
        end else if (tgt != bus_r) begin
          state_nxt = low_state_of(tgt);
          bus_nxt   = tgt;
        end
      end
      seg_pm_pkg::ST_B3: begin
        if (tgt != seg_pm_pkg::BUS_B3) begin
          state_nxt = seg_pm_pkg::ST_WAKE;
          tmr_nxt   = TW'(BUS_RST_CYCLES);
        end
      end
      seg_pm_pkg::ST_WAKE: begin
        // Power back, bus reset held, then active idle in B0
        if (tmr_r == '0) begin
          state_nxt = seg_pm_pkg::ST_B0;
          bus_nxt   = seg_pm_pkg::BUS_B0;
          tmr_nxt   = TW'(SETTLE_CYCLES);
        end
      end
      default: begin
        state_nxt = seg_pm_pkg::ST_B0;
        bus_nxt   = seg_pm_pkg::BUS_B0;
        tmr_nxt   = '0;
      end
    endcase
    quiesce_nxt      = (state_nxt != seg_pm_pkg::ST_B0) && (state_nxt != seg_pm_pkg::ST_WAKE);
    ctrl_nxt.pwr_en  = (state_nxt != seg_pm_pkg::ST_B3);
    // One shared clock: stopped low in B2, absent in B3
    ctrl_nxt.clk_run = (state_nxt != seg_pm_pkg::ST_B2) && (state_nxt != seg_pm_pkg::ST_B3);
    ctrl_nxt.rst_n   = (state_nxt != seg_pm_pkg::ST_B3) && (state_nxt != seg_pm_pkg::ST_WAKE);
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r   <= seg_pm_pkg::ST_B0;
      bus_r     <= seg_pm_pkg::BUS_B0;
      tmr_r     <= '0;
      abort_r   <= 1'b0;
      quiesce_r <= 1'b0;
      ctrl_r    <= seg_pm_pkg::SEG_CTRL_RESET;
    end else begin
      state_r   <= state_nxt;
      bus_r     <= bus_nxt;
      tmr_r     <= tmr_nxt;
      abort_r   <= abort_nxt;
      quiesce_r <= quiesce_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  assign master_abort_out = abort_r;
  assign seg_ctrl_out     = ctrl_r;
  assign bus_state_out    = bus_r;
  // Software must not touch the segment while this is high
  assign settle_busy_out  = (state_r == seg_pm_pkg::ST_B0) && (tmr_r != '0);

endmodule

`default_nettype wire

/* seg_power_seq_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module seg_power_seq_chk #(
  parameter int SETTLE_CYCLES  = 20,
  parameter int BUS_RST_CYCLES = 4
) (
  // Clocks and reset
  input wire logic                   sys_clk_in,
  input wire logic                   reset_in,
  input wire logic                   link_clk_in,
  // Control and accesses
  input wire seg_pm_pkg::dev_state_t dev_state_in,
  input wire logic                   d3hot_b2_in,
  input wire logic                   acc_req_in,
  input wire logic                   acc_ready_out,
  input wire logic                   acc_fwd_out,
  input wire logic                   master_abort_out,
  input wire logic                   frame_n_in,
  input wire logic                   irdy_n_in,
  input wire logic                   gnt_block_out,
  // Segment control and status
  input wire seg_pm_pkg::seg_ctrl_t  seg_ctrl_out,
  input wire seg_pm_pkg::bus_state_t bus_state_out,
  input wire logic                   settle_busy_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_leave_b0;
    $past(bus_state_out) == seg_pm_pkg::BUS_B0 && bus_state_out != seg_pm_pkg::BUS_B0;
  endsequence
  sequence s_leave_b3;
    $past(bus_state_out) == seg_pm_pkg::BUS_B3 && bus_state_out != seg_pm_pkg::BUS_B3;
  endsequence

  chk_fwd_only_b0: assert property (acc_fwd_out |-> acc_req_in && bus_state_out == seg_pm_pkg::BUS_B0)
    else $error("forward outside B0");
  chk_abort_taken: assert property (acc_req_in && acc_ready_out && bus_state_out != seg_pm_pkg::BUS_B0
    |=> master_abort_out)
    else $error("no abort for access off B0");
  chk_abort_cause: assert property (master_abort_out
    |-> $past(acc_req_in && acc_ready_out && bus_state_out != seg_pm_pkg::BUS_B0))
    else $error("abort without cause");
  chk_exit_drained: assert property (s_leave_b0 |-> $past(!acc_ready_out))
    else $error("B0 left without drain");
  chk_b0_b1_ctrl: assert property (bus_state_out inside {seg_pm_pkg::BUS_B0, seg_pm_pkg::BUS_B1}
    |-> seg_ctrl_out == seg_pm_pkg::SEG_CTRL_RESET)
    else $error("B0 or B1 controls wrong");
  chk_b2_clk_low: assert property (bus_state_out == seg_pm_pkg::BUS_B2
    |-> seg_ctrl_out.pwr_en && !seg_ctrl_out.clk_run)
    else $error("B2 controls wrong");
  chk_b3_power_off: assert property ($changed(bus_state_out) && bus_state_out == seg_pm_pkg::BUS_B3
    |-> !seg_ctrl_out.pwr_en)
    else $error("B3 entered powered");
  chk_wake_reset: assert property (s_leave_b3 |-> bus_state_out == seg_pm_pkg::BUS_B0
    && $past(!seg_ctrl_out.rst_n) && seg_ctrl_out.rst_n)
    else $error("B3 exit without bus reset");
  chk_settle_start: assert property ($past(bus_state_out) == seg_pm_pkg::BUS_B2
    && bus_state_out == seg_pm_pkg::BUS_B0 |=> settle_busy_out)
    else $error("settle not started");
  chk_gnt_low: assert property (@(posedge link_clk_in) disable iff (reset_in)
    (bus_state_out == seg_pm_pkg::BUS_B1) [*6] |-> gnt_block_out)
    else $error("grants not withheld in B1");
  chk_reset_b0: assert property (@(posedge sys_clk_in) disable iff (1'b0) reset_in
    |-> bus_state_out == seg_pm_pkg::BUS_B0 && seg_ctrl_out == seg_pm_pkg::SEG_CTRL_RESET)
    else $error("reset not B0");
endmodule

`default_nettype wire

/* seg_agent.sv */
`timescale 1ns/1ps
`default_nettype none

module seg_agent (
  // Supply and clock control
  input  wire logic pwr_en_in,
  input  wire logic clk_run_in,
  // A function holding the bus busy
  input  wire logic busy_in,
  // Shared clock and pins
  output logic      link_clk_out,
  output logic      frame_n_out,
  output logic      irdy_n_out
);
  // One clock for all functions, low when stopped or unpowered
  initial begin
    link_clk_out = 1'b0;
    forever #40 link_clk_out = (pwr_en_in && clk_run_in) ? ~link_clk_out : 1'b0;
  end
  // Pulled up when no function drives; no PME modelled
  initial begin
    frame_n_out = 1'b1;
    irdy_n_out  = 1'b1;
    forever begin
      @(posedge link_clk_out);
      frame_n_out <= !busy_in;
      irdy_n_out  <= !busy_in;
    end
  end
endmodule

`default_nettype wire

/* test_secondary_bus_power_state_control.sv */
`timescale 1ns/1ps
`default_nettype none

module test_secondary_bus_power_state_control;
  localparam int SETTLE  = 20;
  localparam int RST_LEN = 4;
  logic                   sys_clk_in;
  logic                   reset_in;
  logic                   d3hot_b2_in;
  logic                   acc_req_in;
  logic                   busy;
  seg_pm_pkg::dev_state_t dev_state_in;
  seg_pm_pkg::bus_state_t bus_state;
  seg_pm_pkg::seg_ctrl_t  ctrl;
  wire logic              lclk, frame_n, irdy_n, rdy, fwd, abrt, gnt, settle;
  int                     n_errors;
  int                     check_count;
  int                     n;

  seg_power_seq #(.SETTLE_CYCLES(SETTLE), .BUS_RST_CYCLES(RST_LEN)) i_dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .link_clk_in(lclk), .dev_state_in(dev_state_in),
    .d3hot_b2_in(d3hot_b2_in), .acc_req_in(acc_req_in), .acc_ready_out(rdy), .acc_fwd_out(fwd),
    .master_abort_out(abrt), .frame_n_in(frame_n), .irdy_n_in(irdy_n), .gnt_block_out(gnt),
    .seg_ctrl_out(ctrl), .bus_state_out(bus_state), .settle_busy_out(settle));
  seg_agent i_agent (.pwr_en_in(ctrl.pwr_en), .clk_run_in(ctrl.clk_run), .busy_in(busy),
    .link_clk_out(lclk), .frame_n_out(frame_n), .irdy_n_out(irdy_n));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk_in);
  endtask

  task automatic go(input seg_pm_pkg::dev_state_t d, input seg_pm_pkg::bus_state_t b);
    dev_state_in = d;
    for (n = 0; n < 400 && bus_state !== b; n++) tick(1);
    check("bus_state", 3'(bus_state), 3'(b));
  endtask

  task automatic t_access();
    check("ctrl", ctrl, 3'h7);
    acc_req_in = 1'b1;
    #1 check("fwd", 3'(fwd), 3'h1);
    tick(1);
    check("abort", 3'(abrt), 3'h0);
    acc_req_in = 1'b0;
    $display("t_access done");
  endtask

  task automatic t_drain();
    busy = 1'b1;
    tick(24);
    dev_state_in = seg_pm_pkg::DEV_D1;
    tick(40);
    check("bus_state", 3'(bus_state), 3'h0);
    check("ready", 3'(rdy), 3'h0);
    dev_state_in = seg_pm_pkg::DEV_D0;
    tick(2);
    check("ready", 3'(rdy), 3'h1);
    check("bus_state", 3'(bus_state), 3'h0);
    busy = 1'b0;
    go(seg_pm_pkg::DEV_D1, seg_pm_pkg::BUS_B1);
    tick(20);
    check("gnt", 3'(gnt), 3'h1);
    acc_req_in = 1'b1;
    tick(2);
    check("abort", 3'(abrt), 3'h1);
    check("fwd", 3'(fwd), 3'h0);
    acc_req_in = 1'b0;
    tick(1);
    check("abort", 3'(abrt), 3'h0);
    $display("t_drain done");
  endtask

  task automatic t_clock_stop();
    go(seg_pm_pkg::DEV_D2, seg_pm_pkg::BUS_B2);
    check("ctrl", ctrl, 3'h5);
    go(seg_pm_pkg::DEV_D0, seg_pm_pkg::BUS_B0);
    for (n = 0; n < 100 && settle === 1'b1; n++) tick(1);
    check("settle_len", n, SETTLE);
    go(seg_pm_pkg::DEV_D3HOT, seg_pm_pkg::BUS_B2);
    $display("t_clock_stop done");
  endtask

  task automatic t_power_off();
    d3hot_b2_in = 1'b0;
    go(seg_pm_pkg::DEV_D3HOT, seg_pm_pkg::BUS_B3);
    check("pwr_en", 3'(ctrl.pwr_en), 3'h0);
    dev_state_in = seg_pm_pkg::DEV_D0;
    for (n = 0; n < 50 && ctrl.pwr_en !== 1'b1; n++) tick(1);
    for (n = 0; n < 50 && ctrl.rst_n === 1'b0; n++) tick(1);
    check("rst_len", n, RST_LEN + 1);
    check("bus_state", 3'(bus_state), 3'h0);
    go(seg_pm_pkg::DEV_D3COLD, seg_pm_pkg::BUS_B3);
    reset_in = 1'b1;
    dev_state_in = seg_pm_pkg::DEV_D0;
    tick(10);
    check("bus_state", 3'(bus_state), 3'h0);
    check("ctrl", ctrl, 3'h7);
    reset_in = 1'b0;
    $display("t_power_off done");
  endtask

  initial begin
    n_errors = 0;
    check_count = 0;
    reset_in = 1'b1;
    d3hot_b2_in = 1'b1;
    acc_req_in = 1'b0;
    busy = 1'b0;
    dev_state_in = seg_pm_pkg::DEV_D0;
    tick(20);
    reset_in = 1'b0;
    t_access();
    t_drain();
    t_clock_stop();
    t_power_off();
    tick(10);
    give_verdict();
  end

  // Whole run is a few hundred cycles
  initial begin
    #1ms;
    n_errors++;
    give_verdict();
  end
endmodule

bind seg_power_seq seg_power_seq_chk #(.SETTLE_CYCLES(SETTLE_CYCLES), .BUS_RST_CYCLES(BUS_RST_CYCLES)) i_chk (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .link_clk_in(link_clk_in), .dev_state_in(dev_state_in),
  .d3hot_b2_in(d3hot_b2_in), .acc_req_in(acc_req_in), .acc_ready_out(acc_ready_out),
  .acc_fwd_out(acc_fwd_out), .master_abort_out(master_abort_out), .frame_n_in(frame_n_in),
  .irdy_n_in(irdy_n_in), .gnt_block_out(gnt_block_out), .seg_ctrl_out(seg_ctrl_out),
  .bus_state_out(bus_state_out), .settle_busy_out(settle_busy_out));

`default_nettype wire
